// ===== core/cdcacm_map.svh
/*
  Register offsets, field positions, reset values and protocol codes of
  the serial-class USB function block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CDCACM_MAP_SVH
`define CDCACM_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CA_OFS_CTRL 8'h00
`define CA_OFS_RXLEN 8'h04
`define CA_OFS_TXLEN 8'h08
`define CA_OFS_RXCNT 8'h0C
`define CA_OFS_STAT 8'h10
`define CA_OFS_MASK 8'h14
`define CA_OFS_RATE 8'h18
`define CA_OFS_FMT 8'h1C
`define CA_OFS_LINE 8'h20
`define CA_OFS_SSTATE 8'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CA_CTRL_RXGO 0
`define CA_CTRL_TXGO 1
`define CA_EV_RX 0
`define CA_EV_TX 1
`define CA_EV_NTF 2
`define CA_EV_LC 3
`define CA_EV_SEQ 4
`define CA_EV_W 5
`define CA_SS_OVR 6
`define CA_SS_PAR 5
`define CA_SS_FRM 4

// ----------------------------------------------------------------
// Reset values and protocol codes
// ----------------------------------------------------------------
`define CA_RST_MASK 5'h00
`define CA_RST_LC 8'h00
`define CA_NTF_TYPE 8'hA1
`define CA_NTF_SERIAL 8'h20
`define CA_NTF_LEN 8'h02
`define CA_NTF_LAST 4'h9
`define CA_REQ_SET_LC 8'h20
`define CA_REQ_GET_LC 8'h21
`define CA_REQ_SET_CLS 8'h22
`define CA_RT_OUT 8'h21
`define CA_RT_IN 8'hA1
`define CA_LC_LAST 3'h6

`endif

// ===== core/cdcacm_pkg.sv
/*
  Types of the serial-class USB function block.
  Assumes no surroundings beyond the compiler.
*/
package cdcacm_pkg;

  // ----------------------------------------------------------------
  // Control transfer stage, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    stage_idle_setup = 7'h01,
    stage_read_data = 7'h02,
    stage_write_data = 7'h04,
    stage_write_nodata_status = 7'h08,
    stage_read_status = 7'h10,
    stage_write_status = 7'h20,
    stage_sequence_error = 7'h40
  } cdcacm_stage_t;

endpackage

// ===== core/cdcacm_fn.sv
/*
  Serial-class USB function endpoints: bulk OUT/IN data, interrupt
  serial-state notifications, control stage tracking, register file.
  Assumes a USB engine on the same clock that presents endpoint byte
  streams with valid/ready and control-transfer event pulses, and a
  local serial port on the same clock that reports error levels.
*/
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "cdcacm_map.svh"

// Contract
// - only serial-state notification code 0x20 sent
// - notify host on local port state change; code notifies on error onset only, not when an error clears
// - detect overrun, parity, framing errors
// - notify on error onset, never repeat
// - bitmap D6 overrun D5 parity D4 framing
// - bits D3 to D0 always zero
// - header A1,20,0,0,len 2, then bitmap
// - notifications go out on interrupt endpoint 3
// - OUT data on EP2, IN data EP1
// - bulk max packet 64 bytes
// - receive ends at count or short packet
// - full packets below count keep receiving
// - transmit exactly requested bytes then complete
// - signal completion after notification sent
// - track control transfer in seven stages
// - accept 0x20,0x21,0x22, reject other requests
// - line coding is seven bytes
module cdcacm_fn #(
  parameter int LEN_W = 16,
  parameter int MPS = 64
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic IRQ_O,
  // Bulk OUT endpoint 2 from the USB engine
  input wire logic EP2_VALID_I,
  input wire logic [7:0] EP2_DATA_I,
  input wire logic EP2_LAST_I,
  input wire logic EP2_ZLP_I,
  output logic EP2_READY_O,
  // Received bytes to the local side
  output logic RX_VALID_O,
  output logic [7:0] RX_DATA_O,
  output logic RX_DONE_O,
  // Bytes to send from the local side
  input wire logic TX_VALID_I,
  input wire logic [7:0] TX_DATA_I,
  output logic TX_READY_O,
  output logic TX_DONE_O,
  // Bulk IN endpoint 1 to the USB engine
  output logic EP1_VALID_O,
  output logic [7:0] EP1_DATA_O,
  output logic EP1_LAST_O,
  input wire logic EP1_READY_I,
  // Interrupt IN endpoint 3 to the USB engine
  output logic EP3_VALID_O,
  output logic [7:0] EP3_DATA_O,
  output logic EP3_LAST_O,
  input wire logic EP3_READY_I,
  output logic NTF_DONE_O,
  // Local serial port error levels
  input wire logic OVR_ERR_I,
  input wire logic PAR_ERR_I,
  input wire logic FRM_ERR_I,
  // Control transfer events
  input wire logic SETUP_VALID_I,
  input wire logic [7:0] SETUP_TYPE_I,
  input wire logic [7:0] SETUP_REQ_I,
  input wire logic [15:0] SETUP_VAL_I,
  input wire logic [15:0] SETUP_LEN_I,
  input wire logic CTRL_WVALID_I,
  input wire logic [7:0] CTRL_WDATA_I,
  input wire logic CTRL_RD_I,
  input wire logic CTRL_DATA_END_I,
  input wire logic CTRL_STATUS_END_I,
  output logic [7:0] CTRL_RDATA_O,
  output logic CTRL_STALL_O,
  output logic [6:0] CTRL_STAGE_O
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [LEN_W-1:0] byte_wr(
    input logic [LEN_W-1:0] old,
    input logic [31:0] d,
    input logic [3:0] s
  );
    logic [31:0] r;
    r = 32'(old);
    for (int i = 0; i < 4; i++) if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    return r[LEN_W-1:0];
  endfunction
  function automatic logic [7:0] ntf_byte(
    input logic [3:0] idx,
    input logic [2:0] errs
  );
    logic [15:0] map;
    map = 16'h0000;
    map[`CA_SS_OVR] = errs[2];
    map[`CA_SS_PAR] = errs[1];
    map[`CA_SS_FRM] = errs[0];
    case (idx)
      4'h0: ntf_byte = `CA_NTF_TYPE;
      4'h1: ntf_byte = `CA_NTF_SERIAL;
      4'h6: ntf_byte = `CA_NTF_LEN;
      4'h8: ntf_byte = map[7:0];
      4'h9: ntf_byte = map[15:8];
      default: ntf_byte = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire bus_req = CYC_I && STB_I && !ACK_O;
  wire bus_wr = bus_req && WE_I;
  wire wr_ctrl = bus_wr && ADR_I == `CA_OFS_CTRL && SEL_I[0];
  wire wr_rxlen = bus_wr && ADR_I == `CA_OFS_RXLEN;
  wire wr_txlen = bus_wr && ADR_I == `CA_OFS_TXLEN;
  wire wr_stat = bus_wr && ADR_I == `CA_OFS_STAT && SEL_I[0];
  wire wr_mask = bus_wr && ADR_I == `CA_OFS_MASK && SEL_I[0];
  logic rx_busy;
  logic tx_busy;
  logic [LEN_W-1:0] rx_len;
  logic [LEN_W-1:0] tx_len;
  logic [LEN_W-1:0] rx_cnt;
  logic [LEN_W-1:0] tx_left;
  logic [6:0] rx_pkt;
  logic [6:0] tx_pkt;
  logic [`CA_EV_W-1:0] stat;
  logic [`CA_EV_W-1:0] mask;
  logic [2:0] err_q;
  logic [2:0] pend;
  logic [2:0] ss;
  logic [3:0] ntf_idx;
  logic [1:0] ctl_lines;
  logic [7:0] lc [0:6];
  logic [2:0] lc_idx;
  logic [7:0] cur_req;
  cdcacm_pkg::cdcacm_stage_t stage;
  cdcacm_pkg::cdcacm_stage_t next_stage;
  wire rx_go = wr_ctrl && DAT_I[`CA_CTRL_RXGO] && !rx_busy;
  wire tx_go = wr_ctrl && DAT_I[`CA_CTRL_TXGO] && !tx_busy;
  wire [15:0] ss_map = {9'h000, ss, 4'h0};
  wire [31:0] rd_ctrl = {30'h0, tx_busy, rx_busy};
  wire [31:0] rd_rate = {lc[3], lc[2], lc[1], lc[0]};
  wire [31:0] rd_fmt = {8'h00, lc[6], lc[5], lc[4]};
  wire [31:0] rd_line = {17'h0, stage, 6'h00, ctl_lines};
  logic [31:0] rd_mux;
  always_comb begin
    case (ADR_I)
      `CA_OFS_CTRL: rd_mux = rd_ctrl;
      `CA_OFS_RXLEN: rd_mux = 32'(rx_len);
      `CA_OFS_TXLEN: rd_mux = 32'(tx_len);
      `CA_OFS_RXCNT: rd_mux = 32'(rx_cnt);
      `CA_OFS_STAT: rd_mux = 32'(stat);
      `CA_OFS_MASK: rd_mux = 32'(mask);
      `CA_OFS_RATE: rd_mux = rd_rate;
      `CA_OFS_FMT: rd_mux = rd_fmt;
      `CA_OFS_LINE: rd_mux = rd_line;
      `CA_OFS_SSTATE: rd_mux = 32'(ss_map);
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus answer, one cycle after the request
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h00000000;
    end else begin
      ACK_O <= bus_req;
      DAT_O <= bus_req && !WE_I ? rd_mux : 32'h00000000;
    end
  end
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_len <= '0;
      tx_len <= '0;
      mask <= `CA_RST_MASK;
    end else begin
      if (wr_rxlen) rx_len <= byte_wr(rx_len, DAT_I, SEL_I);
      if (wr_txlen) tx_len <= byte_wr(tx_len, DAT_I, SEL_I);
      if (wr_mask) mask <= DAT_I[`CA_EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Receive path, OUT endpoint 2
  // ----------------------------------------------------------------
  assign EP2_READY_O = rx_busy;
  wire rx_take = EP2_VALID_I && rx_busy;
  wire [LEN_W-1:0] rx_cnt_n = rx_cnt + 1'b1;
  wire [6:0] rx_pkt_n = rx_pkt + 1'b1;
  wire rx_short = rx_pkt_n < 7'(MPS);
  wire rx_full = rx_cnt_n >= rx_len;
  wire rx_end = rx_busy && ((rx_take && EP2_LAST_I && (rx_full || rx_short))
                || EP2_ZLP_I);
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_busy <= 1'b0;
      rx_cnt <= '0;
      rx_pkt <= 7'h00;
      RX_VALID_O <= 1'b0;
      RX_DATA_O <= 8'h00;
      RX_DONE_O <= 1'b0;
    end else begin
      RX_VALID_O <= rx_take;
      RX_DONE_O <= rx_end;
      if (rx_take) RX_DATA_O <= EP2_DATA_I;
      if (rx_go) begin
        rx_busy <= 1'b1;
        rx_cnt <= '0;
        rx_pkt <= 7'h00;
      end else if (rx_take) begin
        rx_cnt <= rx_cnt_n;
        // A full packet below the count keeps the request open
        rx_pkt <= EP2_LAST_I ? 7'h00 : rx_pkt_n;
      end
      if (rx_end) rx_busy <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit path, IN endpoint 1
  // ----------------------------------------------------------------
  assign TX_READY_O = tx_left != '0 && (!EP1_VALID_O || EP1_READY_I);
  wire tx_take = TX_VALID_I && TX_READY_O;
  wire tx_pkt_end = tx_pkt == 7'(MPS - 1) || tx_left == LEN_W'(1);
  wire tx_end = tx_busy && ((EP1_VALID_O && EP1_READY_I && EP1_LAST_O
                && tx_left == '0) || tx_len == '0 && tx_left == '0);
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tx_busy <= 1'b0;
      tx_left <= '0;
      tx_pkt <= 7'h00;
      EP1_VALID_O <= 1'b0;
      EP1_DATA_O <= 8'h00;
      EP1_LAST_O <= 1'b0;
      TX_DONE_O <= 1'b0;
    end else begin
      TX_DONE_O <= tx_end;
      if (tx_go) begin
        tx_busy <= 1'b1;
        tx_left <= tx_len;
        tx_pkt <= 7'h00;
      end else if (tx_end) begin
        tx_busy <= 1'b0;
      end
      if (tx_take) begin
        EP1_VALID_O <= 1'b1;
        EP1_DATA_O <= TX_DATA_I;
        EP1_LAST_O <= tx_pkt_end;
        tx_pkt <= tx_pkt_end ? 7'h00 : tx_pkt + 1'b1;
        tx_left <= tx_left - 1'b1;
      end else if (EP1_READY_I) begin
        EP1_VALID_O <= 1'b0;
        EP1_LAST_O <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial-state notification, interrupt endpoint 3
  // ----------------------------------------------------------------
  wire [2:0] err_now = {OVR_ERR_I, PAR_ERR_I, FRM_ERR_I};
  wire [2:0] err_rise = err_now & ~err_q;
  wire ntf_start = !EP3_VALID_O && pend != 3'h0;
  wire ntf_step = EP3_VALID_O && EP3_READY_I;
  wire ntf_end = ntf_step && ntf_idx == `CA_NTF_LAST;
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      err_q <= 3'h0;
      pend <= 3'h0;
      ss <= 3'h0;
      ntf_idx <= 4'h0;
      EP3_VALID_O <= 1'b0;
      EP3_DATA_O <= 8'h00;
      EP3_LAST_O <= 1'b0;
      NTF_DONE_O <= 1'b0;
    end else begin
      err_q <= err_now;
      // A new onset in the launch cycle stays pending
      pend <= (ntf_start ? 3'h0 : pend) | err_rise;
      NTF_DONE_O <= ntf_end;
      if (ntf_start) begin
        ss <= pend;
        ntf_idx <= 4'h0;
        EP3_VALID_O <= 1'b1;
        EP3_DATA_O <= ntf_byte(4'h0, pend);
        EP3_LAST_O <= 1'b0;
      end else if (ntf_end) begin
        EP3_VALID_O <= 1'b0;
        EP3_LAST_O <= 1'b0;
      end else if (ntf_step) begin
        ntf_idx <= ntf_idx + 1'b1;
        EP3_DATA_O <= ntf_byte(ntf_idx + 1'b1, ss);
        EP3_LAST_O <= ntf_idx + 1'b1 == `CA_NTF_LAST;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control transfer stages and class requests
  // ----------------------------------------------------------------
  wire req_ok = (SETUP_TYPE_I == `CA_RT_OUT && (SETUP_REQ_I == `CA_REQ_SET_LC
                || SETUP_REQ_I == `CA_REQ_SET_CLS))
                || (SETUP_TYPE_I == `CA_RT_IN && SETUP_REQ_I == `CA_REQ_GET_LC);
  wire setup_bad = SETUP_VALID_I && !req_ok;
  wire status_bad = CTRL_STATUS_END_I && !(stage == cdcacm_pkg::stage_read_status
                    || stage == cdcacm_pkg::stage_write_status
                    || stage == cdcacm_pkg::stage_write_nodata_status);
  wire data_bad = CTRL_DATA_END_I && !(stage == cdcacm_pkg::stage_read_data
                  || stage == cdcacm_pkg::stage_write_data);
  wire seq_ev = !SETUP_VALID_I && (status_bad || data_bad);
  wire lc_done = CTRL_STATUS_END_I && stage == cdcacm_pkg::stage_write_status
                 && cur_req == `CA_REQ_SET_LC;
  wire lc_wr = CTRL_WVALID_I && stage == cdcacm_pkg::stage_write_data
               && cur_req == `CA_REQ_SET_LC && lc_idx <= `CA_LC_LAST;
  always_comb begin
    next_stage = stage;
    if (SETUP_VALID_I) begin
      if (!req_ok) next_stage = cdcacm_pkg::stage_sequence_error;
      else if (SETUP_LEN_I == 16'h0000) next_stage = cdcacm_pkg::stage_write_nodata_status;
      else if (SETUP_TYPE_I[7]) next_stage = cdcacm_pkg::stage_read_data;
      else next_stage = cdcacm_pkg::stage_write_data;
    end else if (CTRL_DATA_END_I) begin
      case (stage)
        cdcacm_pkg::stage_read_data: next_stage = cdcacm_pkg::stage_read_status;
        cdcacm_pkg::stage_write_data: next_stage = cdcacm_pkg::stage_write_status;
        default: next_stage = cdcacm_pkg::stage_sequence_error;
      endcase
    end else if (CTRL_STATUS_END_I) begin
      case (stage)
        cdcacm_pkg::stage_read_status, cdcacm_pkg::stage_write_status,
        cdcacm_pkg::stage_write_nodata_status: next_stage = cdcacm_pkg::stage_idle_setup;
        default: next_stage = cdcacm_pkg::stage_sequence_error;
      endcase
    end
  end
  assign CTRL_STAGE_O = stage;
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      stage <= cdcacm_pkg::stage_idle_setup;
      cur_req <= 8'h00;
      ctl_lines <= 2'b00;
      lc_idx <= 3'h0;
      CTRL_STALL_O <= 1'b0;
      CTRL_RDATA_O <= 8'h00;
      for (int i = 0; i < 7; i++) lc[i] <= `CA_RST_LC;
    end else begin
      stage <= next_stage;
      CTRL_STALL_O <= setup_bad || seq_ev;
      if (SETUP_VALID_I) begin
        cur_req <= SETUP_REQ_I;
        lc_idx <= 3'h0;
        if (req_ok && SETUP_REQ_I == `CA_REQ_SET_CLS) ctl_lines <= SETUP_VAL_I[1:0];
      end else if (lc_wr) begin
        lc[lc_idx] <= CTRL_WDATA_I;
        lc_idx <= lc_idx + 1'b1;
      end else if (CTRL_RD_I && stage == cdcacm_pkg::stage_read_data
                   && lc_idx <= `CA_LC_LAST) begin
        CTRL_RDATA_O <= lc[lc_idx];
        lc_idx <= lc_idx + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event status and interrupt
  // ----------------------------------------------------------------
  wire [`CA_EV_W-1:0] ev_set = {setup_bad || seq_ev, lc_done, ntf_end, tx_end, rx_end};
  wire [`CA_EV_W-1:0] ev_clr = wr_stat ? DAT_I[`CA_EV_W-1:0] : '0;
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      stat <= '0;
    end else begin
      stat <= (stat & ~ev_clr) | ev_set;
    end
  end
  assign IRQ_O = |(stat & mask);
endmodule // cdcacm_fn

// ===== sim/cdcacm_fn_assertions.sv
/* Port checker of the serial-class function block, bound to cdcacm_fn.
   Assumes one clock and the low-active asynchronous reset. */
`timescale 1ns/1ps
module cdcacm_fn_assertions (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // Endpoint streams
  input wire logic EP2_VALID_I,
  input wire logic EP2_LAST_I,
  input wire logic EP2_ZLP_I,
  input wire logic EP2_READY_O,
  input wire logic RX_DONE_O,
  input wire logic EP1_VALID_O,
  input wire logic EP1_LAST_O,
  input wire logic EP1_READY_I,
  input wire logic TX_DONE_O,
  input wire logic EP3_VALID_O,
  input wire logic [7:0] EP3_DATA_O,
  input wire logic EP3_LAST_O,
  input wire logic EP3_READY_I,
  input wire logic NTF_DONE_O,
  // Control
  input wire logic SETUP_VALID_I,
  input wire logic [7:0] SETUP_REQ_I,
  input wire logic CTRL_STALL_O,
  input wire logic [6:0] CTRL_STAGE_O
);
  logic [3:0] n3;
  logic [5:0] n1;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Byte position in the current notification frame and IN packet
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      n3 <= 4'h0;
      n1 <= 6'h00;
    end else begin
      if (EP3_VALID_O && EP3_READY_I) n3 <= EP3_LAST_O ? 4'h0 : n3 + 4'h1;
      if (EP1_VALID_O && EP1_READY_I) n1 <= EP1_LAST_O ? 6'h00 : n1 + 6'h01;
    end
  end
  ntf_type_a: assert property (EP3_VALID_O && n3 == 4'h0 |-> EP3_DATA_O == 8'hA1)
    else $error("bad request type");
  ntf_code_a: assert property (EP3_VALID_O && n3 == 4'h1 |-> EP3_DATA_O == 8'h20)
    else $error("bad notification code");
  ntf_zero_a: assert property (
    EP3_VALID_O && n3 inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h9} |-> EP3_DATA_O == 8'h00)
    else $error("nonzero header or reserved byte");
  ntf_len_a: assert property (EP3_VALID_O && n3 == 4'h6 |-> EP3_DATA_O == 8'h02)
    else $error("bad length byte");
  ntf_low_a: assert property (
    EP3_VALID_O && n3 == 4'h8 |-> EP3_DATA_O[3:0] == 4'h0 && !EP3_DATA_O[7])
    else $error("unsupported bitmap bit set");
  ntf_last_a: assert property (EP3_VALID_O |-> EP3_LAST_O == (n3 == 4'h9))
    else $error("frame end misplaced");
  ntf_done_a: assert property (EP3_VALID_O && EP3_READY_I && EP3_LAST_O |=> NTF_DONE_O)
    else $error("no notification done");
  rx_done_a: assert property (
    RX_DONE_O |-> $past(EP2_ZLP_I || EP2_VALID_I && EP2_READY_O && EP2_LAST_I))
    else $error("receive done without packet end");
  tx_done_a: assert property (
    EP1_VALID_O && EP1_READY_I && EP1_LAST_O && n1 != 6'h3F |=> TX_DONE_O)
    else $error("no transmit done");
  in_size_a: assert property (EP1_VALID_O && n1 == 6'h3F |-> EP1_LAST_O)
    else $error("IN packet over 64 bytes");
  stage_hot_a: assert property ($onehot(CTRL_STAGE_O))
    else $error("stage not one-hot");
  req_rej_a: assert property (
    SETUP_VALID_I && !(SETUP_REQ_I inside {8'h20, 8'h21, 8'h22})
    |=> CTRL_STALL_O && CTRL_STAGE_O == 7'h40)
    else $error("request not rejected");
endmodule // cdcacm_fn_assertions
bind cdcacm_fn cdcacm_fn_assertions cdcacm_fn_assertions_inst (.*);

// ===== sim/cdcacm_host.sv
/* Host controller model: drives OUT endpoint 2, takes IN endpoints 1 and 3.
   Assumes the bench calls send and zlp just after a rising edge. */
`timescale 1ns/1ps
module cdcacm_host (
  // Clock and pacing
  input wire logic clk_i,
  input wire logic slow_i,
  // OUT endpoint 2
  output logic ep2_valid_o,
  output logic [7:0] ep2_data_o,
  output logic ep2_last_o,
  output logic ep2_zlp_o,
  input wire logic ep2_ready_i,
  // IN endpoints 1 and 3
  input wire logic ep1_valid_i,
  input wire logic [7:0] ep1_data_i,
  input wire logic ep1_last_i,
  output logic ep1_ready_o,
  input wire logic ep3_valid_i,
  input wire logic [7:0] ep3_data_i,
  output logic ep3_ready_o
);
  logic [7:0] ep1_q[$];
  logic [7:0] ep3_q[$];
  int ep1_pk;
  int hung;
  initial begin
    {ep2_valid_o, ep2_data_o, ep2_last_o, ep2_zlp_o, ep1_ready_o, ep3_ready_o} = '0;
  end
  // A slow host withholds ready at random
  always @(posedge clk_i) begin
    if (ep1_valid_i && ep1_ready_o) ep1_q.push_back(ep1_data_i);
    if (ep1_valid_i && ep1_ready_o && ep1_last_i) ep1_pk++;
    if (ep3_valid_i && ep3_ready_o) ep3_q.push_back(ep3_data_i);
    ep1_ready_o <= !slow_i || 1'($urandom_range(1));
    ep3_ready_o <= !slow_i || 1'($urandom_range(1));
  end
  // One OUT packet of n bytes, n at most 64, counting up from b
  task automatic send(input int n, input logic [7:0] b);
    int k;
    for (int i = 0; i < n; i++) begin
      ep2_valid_o <= 1'b1;
      ep2_data_o <= b + 8'(i);
      ep2_last_o <= (i == n - 1);
      @(posedge clk_i);
      for (k = 0; k < 200 && ep2_ready_i !== 1'b1; k++) @(posedge clk_i);
      hung += (k == 200);
    end
    ep2_valid_o <= 1'b0;
    ep2_last_o <= 1'b0;
    ep2_data_o <= ~ep2_data_o;
  endtask
  task automatic zlp();
    ep2_zlp_o <= 1'b1;
    @(posedge clk_i);
    ep2_zlp_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule // cdcacm_host

// ===== sim/tb.sv
/* Self-checking bench of the serial-class function block.
   Assumes the design, its checker and the host model are compiled. */
`timescale 1ns/1ps
`include "cdcacm_map.svh"
module tb;
  logic CLK_I, RSTN_I, CYC_I, STB_I, WE_I, ACK_O, IRQ_O, EP2_VALID_I, EP2_LAST_I, EP2_ZLP_I;
  logic EP2_READY_O, RX_VALID_O, RX_DONE_O, TX_VALID_I, TX_READY_O, TX_DONE_O, EP1_VALID_O;
  logic EP1_LAST_O, EP1_READY_I, EP3_VALID_O, EP3_LAST_O, EP3_READY_I, NTF_DONE_O, OVR_ERR_I;
  logic PAR_ERR_I, FRM_ERR_I, SETUP_VALID_I, CTRL_WVALID_I, CTRL_RD_I, CTRL_DATA_END_I;
  logic CTRL_STATUS_END_I, CTRL_STALL_O, slow;
  logic [3:0] SEL_I;
  logic [4:0] pl;
  logic [6:0] CTRL_STAGE_O;
  logic [7:0] ADR_I, EP2_DATA_I, RX_DATA_O, TX_DATA_I, EP1_DATA_O, EP3_DATA_O, SETUP_TYPE_I;
  logic [7:0] SETUP_REQ_I, CTRL_WDATA_I, CTRL_RDATA_O, b;
  logic [15:0] SETUP_VAL_I, SETUP_LEN_I;
  logic [31:0] DAT_I, DAT_O;
  logic [7:0] rxq[$], txm[$], lc[7], rej[6];
  int num_errors, num_checks, rx_n, tx_n, ntf_n;
  assign {CTRL_STATUS_END_I, CTRL_DATA_END_I, CTRL_RD_I, CTRL_WVALID_I, SETUP_VALID_I} = pl;
  cdcacm_fn cdcacm_fn_inst (.*);
  cdcacm_host host (.clk_i(CLK_I), .slow_i(slow), .ep2_valid_o(EP2_VALID_I),
    .ep2_data_o(EP2_DATA_I), .ep2_last_o(EP2_LAST_I), .ep2_zlp_o(EP2_ZLP_I),
    .ep2_ready_i(EP2_READY_O), .ep1_valid_i(EP1_VALID_O), .ep1_data_i(EP1_DATA_O),
    .ep1_last_i(EP1_LAST_O), .ep1_ready_o(EP1_READY_I), .ep3_valid_i(EP3_VALID_O),
    .ep3_data_i(EP3_DATA_O), .ep3_ready_o(EP3_READY_I));
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    if (RX_VALID_O === 1'b1) rxq.push_back(RX_DATA_O);
    rx_n += (RX_DONE_O === 1'b1);
    tx_n += (TX_DONE_O === 1'b1);
    ntf_n += (NTF_DONE_O === 1'b1);
  end
  task automatic chk_reg(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic chk_byte(input logic [7:0] g, e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  // A used-up wait ends the run as a mismatch
  task automatic give_up(input bit t);
    if (t) begin
      num_errors++;
      wrap_up();
    end
  endtask
  // One classic cycle; a read is compared with e
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    int k;
    {CYC_I, STB_I, WE_I, ADR_I, DAT_I} <= {2'b11, w, a, d};
    @(posedge CLK_I);
    for (k = 0; k < 50 && ACK_O !== 1'b1; k++) @(posedge CLK_I);
    give_up(k == 50);
    if (!w) chk_reg(DAT_O, e);
    {CYC_I, STB_I} <= 2'b00;
    @(posedge CLK_I);
  endtask
  task automatic pulse(input int n);
    pl[n] <= 1'b1;
    @(posedge CLK_I);
    pl <= '0;
    @(posedge CLK_I);
  endtask
  task automatic ctl(input logic [7:0] t, r, input logic [15:0] v, l, input logic [7:0] e);
    {SETUP_TYPE_I, SETUP_REQ_I, SETUP_VAL_I, SETUP_LEN_I} <= {t, r, v, l};
    pulse(0);
    chk_reg({CTRL_STALL_O, CTRL_STAGE_O}, e);
  endtask
  task automatic wait_for(ref int c, input int t);
    for (int k = 0; k < 2000 && c < t; k++) @(posedge CLK_I);
    chk_reg(c, t);
    give_up(c < t);
  endtask
  task automatic tx(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      txm.push_back(8'($urandom));
      TX_VALID_I <= 1'b1;
      TX_DATA_I <= txm[i];
      @(posedge CLK_I);
      for (k = 0; k < 500 && TX_READY_O !== 1'b1; k++) @(posedge CLK_I);
      give_up(k == 500);
    end
    TX_VALID_I <= 1'b0;
  endtask
  task automatic ntf_chk(input logic [15:0] m);
    logic [7:0] ef[10];
    ef = '{8'hA1, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, m[7:0], m[15:8]};
    foreach (ef[i]) chk_byte(host.ep3_q[i], ef[i]);
    chk_reg(host.ep3_q.size(), 10);
    host.ep3_q.delete();
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge CLK_I);
    num_errors++;
    wrap_up();
  end
  initial begin
    RSTN_I = 1'b0;
    {CYC_I, STB_I, WE_I, ADR_I, DAT_I, TX_VALID_I, TX_DATA_I, OVR_ERR_I, PAR_ERR_I} = '0;
    {FRM_ERR_I, SETUP_TYPE_I, SETUP_REQ_I, SETUP_VAL_I, SETUP_LEN_I, CTRL_WDATA_I} = '0;
    {pl, slow} = '0;
    SEL_I = 4'hF;
    void'($urandom(32'h8F18));
    repeat (12) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    @(posedge CLK_I);
    wb(0, `CA_OFS_MASK, 0, 32'h0);
    wb(0, 8'h40, 0, 32'h0);
    wb(1, `CA_OFS_MASK, 32'h4, 0);
    PAR_ERR_I <= 1'b1;
    wait_for(ntf_n, 1);
    ntf_chk(16'h0020);
    chk_reg(IRQ_O, 32'h1);
    repeat (40) @(posedge CLK_I);
    PAR_ERR_I <= 1'b0;
    repeat (40) @(posedge CLK_I);
    chk_reg(ntf_n, 1);
    wb(1, `CA_OFS_MASK, 32'h0, 0);
    chk_reg(IRQ_O, 32'h0);
    wb(1, `CA_OFS_STAT, 32'h4, 0);
    wb(1, `CA_OFS_MASK, 32'h4, 0);
    chk_reg(IRQ_O, 32'h0);
    {OVR_ERR_I, FRM_ERR_I} <= 2'b11;
    wait_for(ntf_n, 2);
    ntf_chk(16'h0050);
    wb(0, `CA_OFS_SSTATE, 0, 32'h50);
    chk_reg(host.ep1_q.size(), 0);
    b = 8'($urandom);
    wb(1, `CA_OFS_RXLEN, 32'h46, 0);
    wb(1, `CA_OFS_CTRL, 32'h1, 0);
    host.send(64, b);
    repeat (5) @(posedge CLK_I);
    chk_reg(rx_n, 0);
    host.send(6, b + 8'h40);
    wait_for(rx_n, 1);
    wb(0, `CA_OFS_RXCNT, 0, 32'h46);
    foreach (rxq[i]) chk_byte(rxq[i], b + 8'(i));
    chk_reg(rxq.size(), 70);
    wb(1, `CA_OFS_RXLEN, 32'h80, 0);
    wb(1, `CA_OFS_CTRL, 32'h1, 0);
    host.send(64, b);
    host.zlp();
    wait_for(rx_n, 2);
    wb(0, `CA_OFS_RXCNT, 0, 32'h40);
    slow <= 1'b1;
    wb(1, `CA_OFS_TXLEN, 32'h42, 0);
    wb(1, `CA_OFS_CTRL, 32'h2, 0);
    tx(66);
    wait_for(tx_n, 1);
    foreach (txm[i]) chk_byte(host.ep1_q[i], txm[i]);
    chk_reg(host.ep1_q.size(), 66);
    chk_reg(host.ep1_pk, 2);
    ctl(8'h21, 8'h20, 16'h0, 16'h7, 8'h04);
    for (int i = 0; i < 7; i++) begin
      lc[i] = 8'($urandom);
      CTRL_WDATA_I <= lc[i];
      pulse(1);
    end
    pulse(3);
    chk_reg(CTRL_STAGE_O, 32'h20);
    pulse(4);
    chk_reg(CTRL_STAGE_O, 32'h01);
    wb(0, `CA_OFS_RATE, 0, {lc[3], lc[2], lc[1], lc[0]});
    wb(0, `CA_OFS_FMT, 0, {8'h00, lc[6], lc[5], lc[4]});
    ctl(8'hA1, 8'h21, 16'h0, 16'h7, 8'h02);
    for (int i = 0; i < 7; i++) begin
      pulse(2);
      chk_byte(CTRL_RDATA_O, lc[i]);
    end
    pulse(3);
    chk_reg(CTRL_STAGE_O, 32'h10);
    pulse(4);
    ctl(8'h21, 8'h22, 16'h3, 16'h0, 8'h08);
    pulse(4);
    wb(0, `CA_OFS_LINE, 0, 32'h0103);
    pulse(4);
    chk_reg({CTRL_STALL_O, CTRL_STAGE_O}, 32'hC0);
    rej = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h23};
    foreach (rej[i]) ctl(8'h21, rej[i], 16'h0, 16'h0, 8'hC0);
    pulse(3);
    chk_reg({CTRL_STALL_O, CTRL_STAGE_O}, 32'hC0);
    wb(0, `CA_OFS_STAT, 0, 32'h1F);
    wb(1, `CA_OFS_STAT, 32'h1F, 0);
    wb(0, `CA_OFS_STAT, 0, 32'h0);
    chk_reg(IRQ_O, 32'h0);
    chk_reg(host.hung, 0);
    wrap_up();
  end
endmodule // tb
